/* File: pkg/sched_pkg.sv */
// constants and types for the instruction issue timing scheduler
//------------------------------------------------------------
// How it works
// - integer alu and compare: latency one, one per cycle
// - branch takes 1/4/6, register branch 1/3/5/6
// - multiply pipelined, data at 3, flags at 4
// - divide unpipelined, 4 to 15 cycles, blocks all
// - separate latency, throughput; single load/store 3/1, 3/2 when split
// - multiple load/store: 3+n/2 latency, 1+n/2 throughput
// - machine state write 6/6 plus serialization
// - debug spr move 4 plus sync; plain read 1
// - interrupt return 6, system call 4, trap 4 taken, 1 not taken
// - sync ops add 6/1/6/3/4 extra cycles
// - barrier 12 waits, crf move 2, xer move 1
// - aligned non-crossing access uses one address calc
// - misaligned or crossing halfword or word access splits address calcs; a byte never splits
// - unaligned multiple transfer raises alignment interrupt
// - units overlap; branch outcome steers instruction stream
// - completion serialized waits for all earlier completions
// - refetch serialized blocks dispatch, then forces refill
//------------------------------------------------------------
package sched_pkg;
    // ------------------------------------------------------------
    // cycle figures
    // ------------------------------------------------------------
    localparam logic [5:0] LAT_ONE       = 6'h01; // alu, compare, plain spr read
    localparam logic [5:0] LAT_CRF       = 6'h02; // move to condition fields
    localparam logic [5:0] LAT_MEM       = 6'h03; // single load or store
    localparam logic [5:0] LAT_MUL_DATA  = 6'h03; // multiply product
    localparam logic [5:0] LAT_MUL_FLAGS = 6'h04; // record form condition bits
    localparam logic [5:0] LAT_SHORT     = 6'h04; // system call, trap, debug spr
    localparam logic [5:0] LAT_MID       = 6'h05; // register branch middle case
    localparam logic [5:0] LAT_LONG      = 6'h06; // msr write, rfi, isync, worst branch
    localparam logic [5:0] LAT_BARRIER   = 6'h0c; // memory barrier
    localparam logic [5:0] DIV_MIN       = 6'h04; // shortest divide
    localparam logic [5:0] DIV_MAX       = 6'h0f; // longest divide
    localparam logic [5:0] SYNC_ISYNC    = 6'h06; // instruction sync extra
    localparam logic [5:0] SYNC_MSYNC    = 6'h01; // memory sync extra
    localparam logic [5:0] SYNC_MSR      = 6'h06; // machine state write extra
    localparam logic [5:0] SYNC_DBG_RD   = 6'h03; // debug spr read extra
    localparam logic [5:0] SYNC_DBG_WR   = 6'h04; // debug spr write extra
    localparam logic [4:0] EA_ONE        = 5'h01; // single address calculation
    localparam logic [4:0] EA_SPLIT      = 5'h02; // split access
    localparam int         WB_DEPTH      = 32;    // writeback schedule length

    // instruction classes presented at issue
    typedef enum logic [4:0] {
        op_alu = 5'b00000, op_br = 5'b00001, op_br_reg = 5'b00010, op_mul = 5'b00011,
        op_div = 5'b00100, op_ldst = 5'b00101, load_multiple_words = 5'b00110,
        op_msr_wr = 5'b00111, op_spr_dbg_rd = 5'b01000, op_spr_dbg_wr = 5'b01001,
        op_spr_rd = 5'b01010, op_rfi = 5'b01011, system_call_op = 5'b01100,
        trap_word_op = 5'b01101, op_isync = 5'b01110, op_msync = 5'b01111,
        op_mbar = 5'b10000, op_mtcrf = 5'b10001, op_mcrxr = 5'b10010
    } op_class_type;

    // one issue request
    typedef struct packed {
        logic         valid;      // request present
        op_class_type op;         // instruction class
        logic [1:0]   sel;        // branch case; bit 0 = trap taken
        logic [3:0]   div_cyc;    // divide early-out length
        logic [4:0]   words;      // word count of a multiple transfer
        logic [2:0]   addr_lo;    // low effective address bits
        logic [1:0]   size;       // 0 byte, 1 half, 2 word
        logic         cross_line; // crosses a cache line
        logic         cross_prot; // crosses a protection boundary
    } issue_req_type;

    // timing answer for an accepted instruction
    typedef struct packed {
        logic [5:0] latency;
        logic [5:0] throughput;
        logic [5:0] flag_lat;
        logic [4:0] ea_cnt;
    } issue_info_type;

    // full decode result
    typedef struct packed {
        issue_info_type info;
        logic [5:0]     sync;    // extra serialization cycles
        logic           cser;    // wait for all earlier completions
        logic           blk;     // block later issue until drained
        logic           refetch; // refill in the completion cycle
        logic           irq;     // alignment interrupt instead of issue
    } sched_dec_type;
endpackage : sched_pkg

/* File: verilog/issue_timing_scheduler.sv */
// issue stall, writeback ordering and timing answer for the execution units
`timescale 1ns/100ps
`default_nettype none
module issue_timing_scheduler #(
    parameter int DEPTH = sched_pkg::WB_DEPTH  // writeback schedule length
) (
    input  wire logic                     i_core_clk,    // core clock
    input  wire logic                     i_rst_b,       // async reset, active low
    input  wire sched_pkg::issue_req_type i_req,         // instruction offered at issue
    output logic                          o_issue_ready, // issue may take a request
    output logic                          o_accept,      // previous cycle request taken
    output var sched_pkg::issue_info_type o_info,        // timing of taken request
    output logic                          o_wb,          // result written back
    output logic                          o_refetch,     // refill the pipeline now
    output logic                          o_align_irq    // alignment interrupt
);
    import sched_pkg::*;

    // ------------------------------------------------------------
    // decode table
    // ------------------------------------------------------------
    function automatic sched_dec_type decode(input issue_req_type r);
        sched_dec_type d;
        logic          mis;
        logic [5:0]    half;
        d = '0;
        mis = 1'b0;
        half = '0;
        d.info.ea_cnt = EA_ONE;
        d.info.latency = LAT_ONE;
        d.info.throughput = LAT_ONE;
        case (r.op)
            op_br: begin
                // looked-ahead branch is one cycle, else 4 or worst 6
                d.info.latency = (r.sel == 2'b00) ? LAT_ONE :
                                 (r.sel == 2'b11) ? LAT_LONG : LAT_SHORT;
            end
            op_br_reg: begin
                d.info.latency = (r.sel == 2'b00) ? LAT_ONE : (r.sel == 2'b01) ? LAT_MEM :
                                 (r.sel == 2'b10) ? LAT_MID : LAT_LONG;
            end
            op_mul: begin
                d.info.latency = LAT_MUL_DATA;
            end
            op_div: begin
                // clamp the operand-driven early-out into range
                d.info.latency = ({2'b00, r.div_cyc} < DIV_MIN) ? DIV_MIN :
                                 ({2'b00, r.div_cyc} > DIV_MAX) ? DIV_MAX : {2'b00, r.div_cyc};
                d.info.throughput = d.info.latency;
                d.blk = 1'b1;
            end
            op_ldst: begin
                // byte never splits; wider access splits when off its size or crossing
                mis = (r.size == 2'b01) ? r.addr_lo[0] : (r.size == 2'b10) ? (r.addr_lo[1:0] != 2'b00) : 1'b0;
                d.info.latency = LAT_MEM;
                d.info.ea_cnt = ((r.size != 2'b00) && (mis || r.cross_line || r.cross_prot)) ?
                                EA_SPLIT : EA_ONE;
                d.info.throughput = {1'b0, d.info.ea_cnt};
            end
            load_multiple_words: begin
                // odd doubleword start costs one more beat, up to the n/2 ceiling
                half = 6'((r.words + {4'h0, r.addr_lo[2]}) >> 1);
                d.info.latency = LAT_MEM + half;
                d.info.throughput = LAT_ONE + half;
                d.info.ea_cnt = (half[4:0] < EA_SPLIT) ? EA_SPLIT : half[4:0];
                d.irq = (r.addr_lo[1:0] != 2'b00);
            end
            op_msr_wr: begin
                d.info.latency = LAT_LONG;
                d.info.throughput = LAT_LONG;
                d.sync = SYNC_MSR;
                d.cser = 1'b1;
                d.blk = 1'b1;
            end
            op_spr_dbg_rd, op_spr_dbg_wr: begin
                d.info.latency = LAT_SHORT;
                d.info.throughput = LAT_SHORT;
                d.sync = (r.op == op_spr_dbg_rd) ? SYNC_DBG_RD : SYNC_DBG_WR;
                d.cser = 1'b1;
                d.blk = 1'b1;
            end
            op_rfi, system_call_op: begin
                d.info.latency = (r.op == op_rfi) ? LAT_LONG : LAT_SHORT;
                d.info.throughput = d.info.latency;
                d.cser = 1'b1;
                d.blk = 1'b1;
                d.refetch = 1'b1;
            end
            trap_word_op: begin
                d.info.latency = r.sel[0] ? LAT_SHORT : LAT_ONE;
                d.info.throughput = d.info.latency;
            end
            op_isync: begin
                d.info.latency = LAT_LONG;
                d.info.throughput = LAT_LONG;
                d.sync = SYNC_ISYNC;
                d.cser = 1'b1;
                d.blk = 1'b1;
                d.refetch = 1'b1;
            end
            op_msync: begin
                d.sync = SYNC_MSYNC;
                d.cser = 1'b1;
                d.blk = 1'b1;
            end
            op_mbar: begin
                // simplification: waits for all earlier work, not just memory ops
                d.info.latency = LAT_BARRIER;
                d.info.throughput = LAT_BARRIER;
                d.cser = 1'b1;
                d.blk = 1'b1;
            end
            op_mtcrf: begin
                d.info.latency = LAT_CRF;
            end
            op_mcrxr: begin
                d.cser = 1'b1;
            end
            default: begin
                // alu, compare and plain spr read keep the one-cycle figures
                d.info.latency = LAT_ONE;
            end
        endcase
        d.info.flag_lat = (r.op == op_mul) ? LAT_MUL_FLAGS : d.info.latency;
        return d;
    endfunction : decode

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0]       hold_q;     // cycles issue stays stalled
    logic [5:0]       drain_q;    // cycles until last scheduled writeback
    logic             blk_q;      // blocking instruction outstanding
    logic [DEPTH-1:0] wb_q;       // writeback schedule, bit k fires in k cycles
    logic [DEPTH-1:0] rf_q;       // refill schedule
    logic             ready_q;
    logic             accept_q;
    logic             irq_q;
    issue_info_type   info_q;

    // ------------------------------------------------------------
    // issue decision
    // ------------------------------------------------------------
    sched_dec_type dec;
    wire           take_raw = i_req.valid && ready_q && (!dec.cser || drain_q == 6'h00);
    wire           take_irq = take_raw && dec.irq;
    wire           accept   = take_raw && !dec.irq;
    // in-order completion: never before the last scheduled result
    wire [5:0]     done_at  = (dec.info.latency > drain_q) ? dec.info.latency : drain_q;
    wire [5:0]     hold_set = dec.blk ? (dec.info.throughput + dec.sync - 6'h01)
                                      : (dec.info.throughput - 6'h01);
    wire [5:0]     hold_d   = accept ? hold_set : ((hold_q != 6'h00) ? hold_q - 6'h01 : 6'h00);
    wire [5:0]     drain_d  = accept ? done_at : ((drain_q != 6'h00) ? drain_q - 6'h01 : 6'h00);
    // a blocking op keeps issue closed until everything up to it has written back
    wire           blk_d    = accept ? dec.blk : (blk_q && drain_d != 6'h00);
    wire           ready_d  = (hold_d == 6'h00) && !blk_d;
    wire [DEPTH-1:0] slot   = DEPTH'(1) << (done_at - 6'h01);

    assign dec = decode(i_req);

    // ------------------------------------------------------------
    // writeback and refill schedules, one bit per future cycle
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_sched
            wire nxt_wb = (g < DEPTH - 1) ? wb_q[(g + 1) % DEPTH] : 1'b0;
            wire nxt_rf = (g < DEPTH - 1) ? rf_q[(g + 1) % DEPTH] : 1'b0;
            // shift toward bit 0 and drop the new result into its ordered slot
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    wb_q[g] <= 1'b0;
                    rf_q[g] <= 1'b0;
                end else begin
                    wb_q[g] <= nxt_wb | (accept & slot[g]);
                    rf_q[g] <= nxt_rf | (accept & dec.refetch & slot[g]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // counters and registered answers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hold_q   <= '0;
            drain_q  <= '0;
            blk_q    <= 1'b0;
            ready_q  <= 1'b0;
            accept_q <= 1'b0;
            irq_q    <= 1'b0;
            info_q   <= '0;
        end else begin
            hold_q   <= hold_d;
            drain_q  <= drain_d;
            blk_q    <= blk_d;
            ready_q  <= ready_d;
            accept_q <= accept;
            irq_q    <= take_irq;
            if (accept) begin
                info_q <= dec.info;
            end
        end
    end

    assign o_issue_ready = ready_q;
    assign o_accept      = accept_q;
    assign o_info        = info_q;
    assign o_wb          = wb_q[0];
    assign o_refetch     = rf_q[0];
    assign o_align_irq   = irq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_take_div;
        accept && i_req.op == op_div;
    endsequence
    sequence s_idle_take(op_class_type op);
        accept && i_req.op == op && drain_q == 6'h00;
    endsequence

    a_alu_one_cycle: assert property (accept && i_req.op == op_alu |=> o_info.latency == 6'h01 && o_info.throughput == 6'h01)
        else $error("alu timing not one cycle");
    a_div_blocks_all: assert property (s_take_div |=> !o_issue_ready [*3])
        else $error("issue open during divide");
    a_mul_data_time: assert property (s_idle_take(op_mul) |-> ##3 o_wb)
        else $error("multiply result not at three cycles");
    // checks the schedule itself, so a drain counter that runs ahead of it is caught
    a_serial_waits: assert property (accept && dec.cser |-> wb_q == '0)
        else $error("serialized op taken with work outstanding");
    a_rfi_refetch: assert property (s_idle_take(op_rfi) |-> ##6 (o_refetch && o_wb))
        else $error("refill not at completion");
    a_msr_hold: assert property (accept && i_req.op == op_msr_wr |=> !o_issue_ready [*8])
        else $error("issue reopened during machine state write");
    a_multi_align_irq: assert property (take_raw && i_req.op == load_multiple_words && i_req.addr_lo[1:0] != 2'b00
                                      |=> o_align_irq && !o_accept)
        else $error("unaligned multiple transfer not trapped");
    a_ea_single: assert property (accept && i_req.op == op_ldst && i_req.addr_lo == 3'h0 && !i_req.cross_line
                                  && !i_req.cross_prot |=> o_info.ea_cnt == 5'h01)
        else $error("aligned access split");
    a_ea_split: assert property (accept && i_req.op == op_ldst && i_req.size != 2'b00 && i_req.cross_line
                                 |=> o_info.ea_cnt == 5'h02)
        else $error("crossing access not split");
    a_br_lookahead: assert property (accept && i_req.op == op_br && i_req.sel == 2'b00 |=> o_info.latency == 6'h01)
        else $error("looked-ahead branch not single cycle");
    a_barrier_len: assert property (s_idle_take(op_mbar) |-> ##12 o_wb)
        else $error("barrier not twelve cycles");
endmodule : issue_timing_scheduler
`default_nettype wire

/* File: dv/instruction_timing_scheduler_tb_top.sv */
// self-checking testbench for the issue timing scheduler
`timescale 1ns/100ps
`default_nettype none
module instruction_timing_scheduler_tb_top;
    import sched_pkg::*;
    // ------------------------------------------------------------
    // case tables and bench signals
    // ------------------------------------------------------------
    typedef struct packed {
        op_class_type op; logic [1:0] sel; logic [3:0] dc; logic [5:0] lat; logic rf;
    } lat_case_type;
    typedef struct packed {
        op_class_type op; logic [1:0] sz; logic [2:0] a; logic [4:0] n; logic [1:0] x;
        logic [5:0] lat; logic [5:0] thr; logic [4:0] ea;
    } info_case_type;
    logic           i_core_clk = 1'b0; // core clock, 5 ns
    logic           i_rst_b;           // reset, active low
    issue_req_type  i_req;             // request offered at issue
    logic           o_issue_ready;
    logic           o_accept;
    issue_info_type o_info;
    logic           o_wb;
    logic           o_refetch;
    logic           o_align_irq;
    int             fail_count  = 0;   // mismatches
    int             comparisons = 0;   // compares made
    int             acc_cnt     = 0;   // accept pulses in a burst window
    int             wb_cnt      = 0;   // writeback pulses in a burst window
    // latency table: every class but the multiple transfer, every branch case, divide bounds
    lat_case_type lat_tab [27] = '{
        '{op_alu,2'h0,4'h0,6'h01,1'b0}, '{op_br,2'h0,4'h0,6'h01,1'b0}, '{op_br,2'h1,4'h0,6'h04,1'b0},
        '{op_br,2'h2,4'h0,6'h04,1'b0}, '{op_br,2'h3,4'h0,6'h06,1'b0}, '{op_br_reg,2'h0,4'h0,6'h01,1'b0},
        '{op_br_reg,2'h1,4'h0,6'h03,1'b0}, '{op_br_reg,2'h2,4'h0,6'h05,1'b0},
        '{op_br_reg,2'h3,4'h0,6'h06,1'b0}, '{op_mul,2'h0,4'h0,6'h03,1'b0}, '{op_div,2'h0,4'h2,6'h04,1'b0},
        '{op_div,2'h0,4'h9,6'h09,1'b0}, '{op_div,2'h0,4'hf,6'h0f,1'b0}, '{op_ldst,2'h0,4'h0,6'h03,1'b0},
        '{op_msr_wr,2'h0,4'h0,6'h06,1'b0}, '{op_spr_dbg_rd,2'h0,4'h0,6'h04,1'b0},
        '{op_spr_dbg_wr,2'h0,4'h0,6'h04,1'b0}, '{op_spr_rd,2'h0,4'h0,6'h01,1'b0},
        '{op_rfi,2'h0,4'h0,6'h06,1'b1}, '{system_call_op,2'h0,4'h0,6'h04,1'b1},
        '{trap_word_op,2'h1,4'h0,6'h04,1'b0}, '{trap_word_op,2'h0,4'h0,6'h01,1'b0},
        '{op_isync,2'h0,4'h0,6'h06,1'b1}, '{op_mbar,2'h0,4'h0,6'h0c,1'b0},
        '{op_msync,2'h0,4'h0,6'h01,1'b0}, '{op_mtcrf,2'h0,4'h0,6'h02,1'b0},
        '{op_mcrxr,2'h0,4'h0,6'h01,1'b0}};
    // placement table: size, address, words, crossing; ea 1f means not judged
    info_case_type info_tab [11] = '{
        '{op_mul,2'h2,3'h0,5'h00,2'h0,6'h03,6'h01,5'h01}, '{op_ldst,2'h2,3'h0,5'h00,2'h0,6'h03,6'h01,5'h01},
        '{op_ldst,2'h1,3'h2,5'h00,2'h0,6'h03,6'h01,5'h01}, '{op_ldst,2'h0,3'h3,5'h00,2'h0,6'h03,6'h01,5'h01},
        '{op_ldst,2'h2,3'h1,5'h00,2'h0,6'h03,6'h02,5'h02}, '{op_ldst,2'h1,3'h1,5'h00,2'h0,6'h03,6'h02,5'h02},
        '{op_ldst,2'h2,3'h0,5'h00,2'h1,6'h03,6'h02,5'h02}, '{op_ldst,2'h2,3'h0,5'h00,2'h2,6'h03,6'h02,5'h02},
        '{load_multiple_words,2'h2,3'h0,5'h04,2'h0,6'h05,6'h03,5'h02},
        '{load_multiple_words,2'h2,3'h4,5'h05,2'h0,6'h06,6'h04,5'h03},
        '{op_msr_wr,2'h2,3'h0,5'h00,2'h0,6'h06,6'h06,5'h1f}};

    always #2.5 i_core_clk = ~i_core_clk;

    // pulse counters used by the burst scenarios
    always @(posedge i_core_clk) begin
        acc_cnt <= acc_cnt + int'(o_accept === 1'b1);
        wb_cnt  <= wb_cnt + int'(o_wb === 1'b1);
    end

    issue_timing_scheduler #(.DEPTH(32)) i_dut (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_req(i_req), .o_issue_ready(o_issue_ready),
        .o_accept(o_accept), .o_info(o_info), .o_wb(o_wb), .o_refetch(o_refetch), .o_align_irq(o_align_irq));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    function automatic issue_req_type mk(op_class_type op, logic [1:0] sel, logic [3:0] dc, logic [4:0] n,
                                         logic [2:0] a, logic [1:0] sz, logic [1:0] x);
        mk = '0;
        mk.valid = 1'b1;
        mk.op = op; mk.sel = sel; mk.div_cyc = dc; mk.words = n;
        mk.addr_lo = a; mk.size = sz; mk.cross_line = x[0]; mk.cross_prot = x[1];
    endfunction : mk

    // offer one request, then watch 40 cycles: writeback slot, stall length, refill
    task automatic run_op(input issue_req_type r, output int wbk, output int lowk, output logic rf,
                          output logic irq, output logic acc);
        int   k;
        logic seen;
        wbk = 0; lowk = 0; rf = 1'b0; seen = 1'b0;
        @(posedge i_core_clk);
        i_req <= r;
        for (k = 0; k < 40 && !seen; k++) begin
            @(posedge i_core_clk);
            #1;
            seen = (o_accept === 1'b1) || (o_align_irq === 1'b1);
        end
        // hang: the request was never taken
        if (!seen) begin
            fail_count++;
            conclude();
        end
        i_req <= '0;
        irq = o_align_irq;
        acc = o_accept;
        for (k = 1; k <= 40; k++) begin
            if (o_wb === 1'b1 && wbk == 0) wbk = k;
            if (o_refetch === 1'b1) rf = 1'b1;
            if (o_issue_ready !== 1'b1) lowk++;
            @(posedge i_core_clk);
            #1;
        end
    endtask : run_op

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_latency;
        int wbk, lowk;
        logic rf, irq, acc;
        foreach (lat_tab[i]) begin
            run_op(mk(lat_tab[i].op, lat_tab[i].sel, lat_tab[i].dc, 5'h0, 3'h0, 2'h2, 2'h0), wbk, lowk, rf, irq, acc);
            check("wb cycle", 8'(wbk), {2'h0, lat_tab[i].lat});
            check("latency", {2'h0, o_info.latency}, {2'h0, lat_tab[i].lat});
            check("refetch", {7'h0, rf}, {7'h0, lat_tab[i].rf});
        end
        // divide of five holds issue until its writeback is drained
        run_op(mk(op_div, 2'h0, 4'h5, 5'h0, 3'h0, 2'h2, 2'h0), wbk, lowk, rf, irq, acc);
        check("div stall", 8'(lowk), 8'h05);
        $display("test latency done");
    endtask : test_latency

    task automatic test_placement;
        int wbk, lowk;
        logic rf, irq, acc;
        foreach (info_tab[i]) begin
            run_op(mk(info_tab[i].op, 2'h0, 4'h0, info_tab[i].n, info_tab[i].a, info_tab[i].sz, info_tab[i].x),
                   wbk, lowk, rf, irq, acc);
            check("latency", {2'h0, o_info.latency}, {2'h0, info_tab[i].lat});
            check("throughput", {2'h0, o_info.throughput}, {2'h0, info_tab[i].thr});
            if (info_tab[i].ea != 5'h1f) check("ea count", {3'h0, o_info.ea_cnt}, {3'h0, info_tab[i].ea});
            if (info_tab[i].op == op_mul) check("flag lat", {2'h0, o_info.flag_lat}, 8'h04);
            // throughput 6 plus 6 sync cycles: next issue twelve cycles after the take
            if (info_tab[i].op == op_msr_wr) check("msr stall", 8'(lowk), 8'h0b);
        end
        // multiple transfer off a word boundary traps and never writes back
        run_op(mk(load_multiple_words, 2'h0, 4'h0, 5'h4, 3'h2, 2'h2, 2'h0), wbk, lowk, rf, irq, acc);
        check("align irq", {7'h0, irq}, 8'h01);
        check("no accept", {7'h0, acc}, 8'h00);
        check("no wb", 8'(wbk), 8'h00);
        $display("test placement done");
    endtask : test_placement

    // back-to-back issue of a pipelined class, one per cycle
    task automatic test_burst(input op_class_type op);
        int acc0;
        int wb0;
        // snapshot instead of clearing: the counters have one driver only
        acc0 = acc_cnt;
        wb0 = wb_cnt;
        repeat (4) begin
            @(posedge i_core_clk);
            i_req <= mk(op, 2'h0, 4'h0, 5'h0, 3'h0, 2'h2, 2'h0);
        end
        @(posedge i_core_clk);
        i_req <= '0;
        repeat (10) @(posedge i_core_clk);
        #1;
        check("burst accepts", 8'(acc_cnt - acc0), 8'h04);
        check("burst wbs", 8'(wb_cnt - wb0), 8'h04);
        $display("test burst done");
    endtask : test_burst

    // multiply, add, machine state write: ordered writeback, serialized take
    task automatic test_order;
        int k;
        int acc2;
        acc2 = 0;
        @(posedge i_core_clk);
        i_req <= mk(op_mul, 2'h0, 4'h0, 5'h0, 3'h0, 2'h2, 2'h0);
        @(posedge i_core_clk);
        i_req <= mk(op_alu, 2'h0, 4'h0, 5'h0, 3'h0, 2'h2, 2'h0);
        @(posedge i_core_clk);
        i_req <= mk(op_msr_wr, 2'h0, 4'h0, 5'h0, 3'h0, 2'h2, 2'h0);
        #1;
        check("alu early wb", {7'h0, o_wb}, 8'h00);
        for (k = 3; k < 40 && acc2 == 0; k++) begin
            @(posedge i_core_clk);
            #1;
            if (o_accept === 1'b1) acc2 = k;
        end
        // hang: the serialized request was never taken
        if (acc2 == 0) begin
            fail_count++;
            conclude();
        end
        i_req <= '0;
        check("serial wait", {7'h0, acc2 >= 4}, 8'h01);
        repeat (30) @(posedge i_core_clk);
        $display("test order done");
    endtask : test_order

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        i_rst_b = 1'b0;
        i_req = '0;
        repeat (2) @(posedge i_core_clk);
        #1;
        check("ready in reset", {7'h0, o_issue_ready}, 8'h00);
        @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        test_latency();
        test_placement();
        test_burst(op_alu);
        test_burst(op_mul);
        test_order();
        conclude();
    end
endmodule : instruction_timing_scheduler_tb_top
`default_nettype wire
